// ===== design/lcpw_consts.svh
// Constants for the LCD parallel write port
`ifndef LCPW_CONSTS_SVH
`define LCPW_CONSTS_SVH

// Register byte addresses
`define LCPW_ADDR_CMD 8'h00
`define LCPW_ADDR_DATA 8'h04
`define LCPW_ADDR_STATUS 8'h08
`define LCPW_ADDR_CTRL 8'h0c
`define LCPW_ADDR_READ 8'h10

// Status and control fields
`define LCPW_ST_BUSY 0
`define LCPW_ST_LVL_LO 1
`define LCPW_ST_LVL_HI 2
`define LCPW_ST_OVF 3
`define LCPW_ST_COL_LO 8
`define LCPW_ST_COL_HI 15
`define LCPW_ST_ROW_LO 16
`define LCPW_ST_ROW_HI 24
`define LCPW_CTRL_POWER 0
`define LCPW_CTRL_RSTN 1
`define LCPW_CTRL_RESET 2'h0

// Timing, ns as printed, cycles derived (least times round up)
`define LCPW_CLK_NS 10
`define LCPW_TWRL_NS 15
`define LCPW_TRDL_NS 45
`define LCPW_WRL_CYC ((`LCPW_TWRL_NS + `LCPW_CLK_NS - 1) / `LCPW_CLK_NS)
`define LCPW_RDL_CYC ((`LCPW_TRDL_NS + `LCPW_CLK_NS - 1) / `LCPW_CLK_NS)

// Display area
`define LCPW_COLS 240
`define LCPW_ROWS 320

`endif

// ===== design/lcpw_pkg.sv
// Types shared by the LCD parallel write port
package lcpw_pkg;

  // Bus cycle sequencer states
  typedef enum logic [1:0] {
    LCPW_IDLE,
    LCPW_SETUP,
    LCPW_STROBE,
    LCPW_HOLD
  } lcpw_phase_t;

  // Kind of bus cycle held in a buffer entry
  typedef enum logic [1:0] {
    LCPW_K_CMD,
    LCPW_K_DATA,
    LCPW_K_READ
  } lcpw_kind_t;

  // One buffered request
  typedef struct packed {
    lcpw_kind_t kind;
    logic [15:0] word;
  } lcpw_entry_t;

endpackage : lcpw_pkg

// ===== design/lcpw_write_port.sv
// Register-fed 8080-style parallel write port towards an LCD driver
`timescale 1ns/1ns
`include "lcpw_consts.svh"

module lcpw_write_port
  import lcpw_pkg::*;
#(
  parameter int COLS = `LCPW_COLS,
  parameter int ROWS = `LCPW_ROWS
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output logic inReady,
  output logic panelSelN,
  output logic cmdOrDataSel,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic [15:0] busDataOut,
  output logic busDataOe,
  input wire logic [15:0] busDataIn,
  output logic lcdPowerOn,
  output logic panelResetN
);

  localparam int CW = $clog2(COLS);
  localparam int RW = $clog2(ROWS);
  localparam logic [3:0] WRL = 4'(`LCPW_WRL_CYC);
  localparam logic [3:0] RDL = 4'(`LCPW_RDL_CYC);
  localparam logic [CW-1:0] COL_LAST = CW'(COLS - 1);
  localparam logic [RW-1:0] ROW_LAST = RW'(ROWS - 1);

  // Whole state of the block
  typedef struct packed {
    lcpw_phase_t phase;
    logic [3:0] cnt;
    lcpw_entry_t [1:0] fifo;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] level;
    lcpw_kind_t curKind;
    logic csN;
    logic dcSel;
    logic wrN;
    logic rdN;
    logic oe;
    logic [15:0] dOut;
    logic [15:0] syncA;
    logic [15:0] syncB;
    logic [15:0] rdCapt;
    logic [CW-1:0] col;
    logic [RW-1:0] row;
    logic overflow;
    logic [1:0] ctrl;
    logic ready;
    logic [31:0] rdData;
  } lcpw_state_t;

  lcpw_state_t s;
  lcpw_state_t next_s;

  logic isPortWr;
  logic push;
  logic pop;
  lcpw_kind_t pushKind;
  lcpw_entry_t head;

  // Decode of writes that queue a bus cycle
  always_comb
  begin
    isPortWr = 1'b0;
    pushKind = LCPW_K_CMD;
    if (regWrite)
    begin
      case (regAddr)
        `LCPW_ADDR_CMD:
        begin
          isPortWr = 1'b1;
          pushKind = LCPW_K_CMD;
        end
        `LCPW_ADDR_DATA:
        begin
          isPortWr = 1'b1;
          pushKind = LCPW_K_DATA;
        end
        `LCPW_ADDR_READ:
        begin
          isPortWr = 1'b1;
          pushKind = LCPW_K_READ;
        end
        default:
        begin
          isPortWr = 1'b0;
          pushKind = LCPW_K_CMD;
        end
      endcase
    end
  end

  // A full buffer drops the write and flags it, since the bus never waits
  assign push = isPortWr && (s.level != 2'h2);
  assign pop = (s.phase == LCPW_IDLE) && (s.level != 2'h0);
  assign head = s.fifo[s.rdPtr];

  // Next-state logic
  always_comb
  begin
    next_s = s;
    // Two-flop synchroniser on the pin inputs
    next_s.syncA = busDataIn;
    next_s.syncB = s.syncA;

    // Buffer fill side, one slot per entry
    for (int i = 0; i < 2; i++)
    begin
      if (push && (s.wrPtr == 1'(i)))
      begin
        next_s.fifo[i].kind = pushKind;
        next_s.fifo[i].word = regWrData[15:0];
      end
    end
    if (push)
    begin
      next_s.wrPtr = ~s.wrPtr;
    end
    if (pop)
    begin
      next_s.rdPtr = ~s.rdPtr;
    end
    next_s.level = s.level + 2'(push) - 2'(pop);
    next_s.ready = (next_s.level != 2'h2);

    // Bus cycle sequencer
    case (s.phase)
      LCPW_IDLE:
      begin
        if (pop)
        begin
          next_s.curKind = head.kind;
          next_s.csN = 1'b0;
          next_s.dcSel = (head.kind != LCPW_K_CMD);
          next_s.oe = (head.kind != LCPW_K_READ);
          // Commands carry only the low byte
          if (head.kind == LCPW_K_CMD)
          begin
            next_s.dOut = {8'h00, head.word[7:0]};
          end
          else
          begin
            next_s.dOut = head.word;
          end
          next_s.phase = LCPW_SETUP;
        end
      end
      LCPW_SETUP:
      begin
        // Select and data settle one cycle before the strobe falls
        if (s.curKind == LCPW_K_READ)
        begin
          next_s.rdN = 1'b0;
          next_s.cnt = RDL - 4'h1;
        end
        else
        begin
          next_s.wrN = 1'b0;
          next_s.cnt = WRL - 4'h1;
        end
        next_s.phase = LCPW_STROBE;
      end
      LCPW_STROBE:
      begin
        if (s.cnt == 4'h0)
        begin
          next_s.wrN = 1'b1;
          next_s.rdN = 1'b1;
          // Synchroniser lag is covered by the long read low time
          if (s.curKind == LCPW_K_READ)
          begin
            next_s.rdCapt = s.syncB;
          end
          next_s.phase = LCPW_HOLD;
        end
        else
        begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      LCPW_HOLD:
      begin
        // Word stays on the bus one cycle past the rising edge
        next_s.csN = 1'b1;
        next_s.oe = 1'b0;
        next_s.phase = LCPW_IDLE;
        // Pixel position: a command restarts, each data word advances
        if (s.curKind == LCPW_K_CMD)
        begin
          next_s.col = '0;
          next_s.row = '0;
        end
        else if (s.curKind == LCPW_K_DATA)
        begin
          if (s.col == COL_LAST)
          begin
            next_s.col = '0;
            next_s.row = (s.row == ROW_LAST) ? '0 : s.row + RW'(1);
          end
          else
          begin
            next_s.col = s.col + CW'(1);
          end
        end
      end
      default:
      begin
        next_s.phase = LCPW_IDLE;
      end
    endcase

    // Control register and sticky overflow; a new drop beats the clear
    if (regWrite && (regAddr == `LCPW_ADDR_CTRL))
    begin
      next_s.ctrl = regWrData[1:0];
    end
    if (regWrite && (regAddr == `LCPW_ADDR_STATUS) && regWrData[`LCPW_ST_OVF])
    begin
      next_s.overflow = 1'b0;
    end
    if (isPortWr && !push)
    begin
      next_s.overflow = 1'b1;
    end

    // Read data stands only in the cycle after the strobe
    next_s.rdData = 32'h0;
    if (regRead)
    begin
      case (regAddr)
        `LCPW_ADDR_STATUS:
        begin
          next_s.rdData[`LCPW_ST_BUSY] = (s.phase != LCPW_IDLE);
          next_s.rdData[`LCPW_ST_LVL_HI:`LCPW_ST_LVL_LO] = s.level;
          next_s.rdData[`LCPW_ST_OVF] = s.overflow;
          next_s.rdData[`LCPW_ST_COL_HI:`LCPW_ST_COL_LO] = 8'(s.col);
          next_s.rdData[`LCPW_ST_ROW_HI:`LCPW_ST_ROW_LO] = 9'(s.row);
        end
        `LCPW_ADDR_CTRL:
        begin
          next_s.rdData[1:0] = s.ctrl;
        end
        `LCPW_ADDR_READ:
        begin
          next_s.rdData[15:0] = s.rdCapt;
        end
        default:
        begin
          next_s.rdData = 32'h0;
        end
      endcase
    end
  end

  // State register; idle bus lines are high and undriven after reset
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s <= '0;
      s.phase <= LCPW_IDLE;
      s.csN <= 1'b1;
      s.wrN <= 1'b1;
      s.rdN <= 1'b1;
      s.ready <= 1'b1;
      s.ctrl <= `LCPW_CTRL_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign regRdData = s.rdData;
  assign inReady = s.ready;
  assign panelSelN = s.csN;
  assign cmdOrDataSel = s.dcSel;
  assign writeStrobeN = s.wrN;
  assign readStrobeN = s.rdN;
  assign busDataOut = s.dOut;
  assign busDataOe = s.oe;
  assign lcdPowerOn = s.ctrl[`LCPW_CTRL_POWER];
  assign panelResetN = s.ctrl[`LCPW_CTRL_RSTN];

  // Checks on the bus cycle
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_BUS16: assert property (
    !s.wrN |-> (s.oe && !s.csN))
    else $error("write strobe low without bus driven and selected");

  AST_WR_RISE: assert property (
    $rose(s.wrN) |-> (s.oe && !s.csN && $stable(s.dOut)) ##1 (s.csN && !s.oe))
    else $error("word not held around write strobe rise");

  AST_SHARED: assert property (
    !s.rdN |-> !s.oe)
    else $error("bus driven during read");

  AST_AREA: assert property (
    (s.col <= COL_LAST) && (s.row <= ROW_LAST))
    else $error("pixel position out of area");

  AST_CMD: assert property (
    (regWrite && regAddr == `LCPW_ADDR_CMD && s.level == 2'h0 && s.phase == LCPW_IDLE)
    |-> ##2 (!s.csN && !s.dcSel && s.dOut == {8'h00, $past(regWrData[7:0], 2)}))
    else $error("command write did not start a command cycle");

  AST_DATA: assert property (
    (regWrite && regAddr == `LCPW_ADDR_DATA && s.level == 2'h0 && s.phase == LCPW_IDLE)
    |-> ##2 (!s.csN && s.dcSel && s.dOut == $past(regWrData[15:0], 2)))
    else $error("data write did not start a data cycle");

  AST_PULSE: assert property (
    $fell(s.wrN) |-> !s.wrN[*2] ##1 s.wrN ##1 s.csN)
    else $error("write strobe pulse or release wrong");

  AST_BACKP: assert property (
    (isPortWr && s.level == 2'h2) |=> (s.overflow && s.level == 2'h2 - 2'($past(pop))))
    else $error("write to full buffer not refused");

  COV_CMD: cover property (!s.wrN && !s.dcSel);
  COV_DATA: cover property (!s.wrN && s.dcSel);
  COV_READ: cover property ($rose(s.rdN));
  COV_FULL: cover property (isPortWr && !push);

endmodule : lcpw_write_port

// ===== sim/lcpw_lcd_model.sv
// Behavioural LCD driver seen across the parallel bus
`timescale 1ns/1ns
module lcpw_lcd_model
(
  input wire logic selN,
  input wire logic dcSel,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic [15:0] bus,
  input wire logic [15:0] readWord,
  output logic [15:0] drive,
  output logic gotDc,
  output logic [15:0] gotWord,
  output int gotCnt
);
  initial gotCnt = 0;

  // Latch on the strobe's rising edge, ignored while deselected
  always @(posedge wrN)
  begin
    if (selN === 1'b0)
    begin
      gotDc = dcSel;
      gotWord = bus;
      gotCnt = gotCnt + 1;
    end
  end

  // No pull-up on the bus, so a released bus shows the inverse word
  assign drive = (!selN && !rdN) ? readWord : ~readWord;
endmodule : lcpw_lcd_model

// ===== sim/lcpw_write_port_bench.sv
// Self-checking bench for the LCD parallel write port
`timescale 1ns/1ns
module lcpw_write_port_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic inReady, panelSelN, cmdOrDataSel, writeStrobeN, readStrobeN;
  logic busDataOe, lcdPowerOn, panelResetN, gotDc;
  logic [15:0] busDataOut, busWire, modelDrive, gotWord;
  logic [15:0] readWord = 16'h5a3c;
  int gotCnt;
  int errorCnt = 0;
  int compares = 0;
  int base;

  typedef struct {logic [7:0] a; logic [31:0] d; logic dc; logic [15:0] w;} lcpw_row_t;

  // Upper bits of the first command write are junk on purpose
  lcpw_row_t rows [5] = '{
    '{8'h00, 32'hffff_ab2c, 1'b0, 16'h002c},
    '{8'h04, 32'hffff_f800, 1'b1, 16'hf800},
    '{8'h04, 32'h0000_07e0, 1'b1, 16'h07e0},
    '{8'h04, 32'h0000_001f, 1'b1, 16'h001f},
    '{8'h00, 32'h0000_0036, 1'b0, 16'h0036}
  };

  initial forever #5 clock = ~clock;

  // Wire level: the block wins while it enables its drivers
  assign busWire = busDataOe ? busDataOut : modelDrive;

  lcpw_write_port dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .inReady(inReady), .panelSelN(panelSelN),
    .cmdOrDataSel(cmdOrDataSel), .writeStrobeN(writeStrobeN),
    .readStrobeN(readStrobeN), .busDataOut(busDataOut), .busDataOe(busDataOe),
    .busDataIn(busWire), .lcdPowerOn(lcdPowerOn), .panelResetN(panelResetN));

  lcpw_lcd_model lcd (.selN(panelSelN), .dcSel(cmdOrDataSel), .wrN(writeStrobeN),
    .rdN(readStrobeN), .bus(busWire), .readWord(readWord), .drive(modelDrive),
    .gotDc(gotDc), .gotWord(gotWord), .gotCnt(gotCnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 q = regRdData;
  endtask : rd

  task automatic waitCap(input int n);
    for (int k = 0; k < 40 && gotCnt < n; k++)
      @(posedge clock);
  endtask : waitCap

  task automatic endSim;
    $display("Compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : endSim

  // Main sequence
  initial
  begin
    logic [31:0] q;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 chk({25'h0, panelSelN, writeStrobeN, readStrobeN, busDataOe, inReady,
      lcdPowerOn, panelResetN}, 32'h74);
    foreach (rows[i])
    begin
      base = gotCnt;
      wr(rows[i].a, rows[i].d);
      waitCap(base + 1);
      repeat (8) @(posedge clock);
      chk(gotCnt - base, 32'h1);
      chk({31'h0, gotDc}, {31'h0, rows[i].dc});
      chk({16'h0, gotWord}, {16'h0, rows[i].w});
    end
    // One full line of pixels wraps the column into the next row
    for (int i = 1; i <= 240; i++)
    begin
      base = gotCnt;
      wr(8'h04, i);
      waitCap(base + 1);
      repeat (3) @(posedge clock);
      if (i == 3)
      begin
        rd(8'h08, q);
        chk(q, 32'h0000_0300);
      end
    end
    rd(8'h08, q);
    chk(q, 32'h0001_0000);
    // Back-to-back writes overrun the two-entry buffer
    base = gotCnt;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clock);
      regAddr <= 8'h04;
      regWrData <= i;
      regWrite <= 1'b1;
    end
    @(posedge clock);
    regWrite <= 1'b0;
    #1 chk({31'h0, inReady}, 32'h0);
    repeat (60) @(posedge clock);
    rd(8'h08, q);
    chk({31'h0, q[3]}, 32'h1);
    // One word in flight plus two buffered; the rest are dropped
    chk(gotCnt - base, 32'h3);
    wr(8'h08, 32'h8);
    rd(8'h08, q);
    chk({31'h0, q[3]}, 32'h0);
    wr(8'h0c, 32'h3);
    rd(8'h0c, q);
    chk({28'h0, q[1:0], lcdPowerOn, panelResetN}, 32'hf);
    rd(8'h00, q);
    chk(q, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, q);
    chk(q, 32'h0);
    wr(8'h10, 32'h0);
    repeat (14) @(posedge clock);
    rd(8'h10, q);
    chk(q, {16'h0, readWord});
    // Reset in mid-run clears control and returns the panel lines to idle
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 chk({25'h0, panelSelN, writeStrobeN, readStrobeN, busDataOe, inReady,
      lcdPowerOn, panelResetN}, 32'h74);
    endSim;
  end

  // Cuts a hang; the full run needs about 2600 cycles
  initial
  begin
    #200000;
    errorCnt++;
    endSim;
  end
endmodule : lcpw_write_port_bench
